// File: rtl/dsnrr_defs.vh
// constants of the dip, swell, no-load and redirect register slice
// assumes inclusion by every design file of the slice
`ifndef DSNRR_DEFS_VH
`define DSNRR_DEFS_VH

// ----------------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------------
`define DSNRR_IDX_DIP_THR 14'h0410
`define DSNRR_IDX_DIP_A 14'h0411
`define DSNRR_IDX_DIP_B 14'h0412
`define DSNRR_IDX_DIP_C 14'h0413
`define DSNRR_IDX_SWELL_THR 14'h0414
`define DSNRR_IDX_SWELL_A 14'h0415
`define DSNRR_IDX_SWELL_B 14'h0416
`define DSNRR_IDX_SWELL_C 14'h0417
`define DSNRR_IDX_NOLOAD 14'h041f
`define DSNRR_IDX_REDIRECT 14'h0424
`define DSNRR_IDX_EVT_EN 14'h04f0
`define DSNRR_IDX_IRQ_STAT 14'h04f1
`define DSNRR_IDX_IRQ_MASK 14'h04f2

// ----------------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------------
`define DSNRR_RMS_W 24
`define DSNRR_RST_DIP_THR 24'h000000
`define DSNRR_RST_DIP_VAL 24'h7fffff
`define DSNRR_RST_SWELL_THR 24'hffffff
`define DSNRR_RST_SWELL_VAL 24'h000000
`define DSNRR_NOLOAD_W 18
`define DSNRR_RST_NOLOAD 18'h00000

// ----------------------------------------------------------------------
// no-load layout: phase base plus flag offset
// ----------------------------------------------------------------------
`define DSNRR_NL_PHASE_A 0
`define DSNRR_NL_PHASE_B 6
`define DSNRR_NL_PHASE_C 12
`define DSNRR_NL_TOTAL_ACTIVE 0
`define DSNRR_NL_TOTAL_REACTIVE 1
`define DSNRR_NL_TOTAL_APPARENT 2
`define DSNRR_NL_FUND_ACTIVE 3
`define DSNRR_NL_FUND_REACTIVE 4
`define DSNRR_NL_FUND_APPARENT 5

// ----------------------------------------------------------------------
// source redirect field and codes
// ----------------------------------------------------------------------
`define DSNRR_SRC_LSB 18
`define DSNRR_SRC_MSB 20
`define DSNRR_RST_SRC 3'h7
`define DSNRR_SRC_CUR_A 3'h0
`define DSNRR_SRC_CUR_B 3'h1
`define DSNRR_SRC_CUR_C 3'h2
`define DSNRR_SRC_CUR_N 3'h3
`define DSNRR_SRC_VOLT_A 3'h4
`define DSNRR_SRC_VOLT_B 3'h5
`define DSNRR_SRC_VOLT_C 3'h6
`define DSNRR_SRC_NATIVE 3'h7
`define DSNRR_ADC_CH 7

// ----------------------------------------------------------------------
// event enables and interrupt bits
// ----------------------------------------------------------------------
`define DSNRR_EVT_W 6
`define DSNRR_EVT_DIP_LSB 0
`define DSNRR_EVT_SWELL_LSB 3
`define DSNRR_RST_EVT 6'h00
`define DSNRR_IRQ_W 7
`define DSNRR_IRQ_DIP_LSB 0
`define DSNRR_IRQ_SWELL_LSB 3
`define DSNRR_IRQ_NOLOAD 6
`define DSNRR_RST_IRQ 7'h00

`endif

// File: rtl/dsnrr_phase_mon.v
// per-phase dip and swell judge with capture of the half-cycle rms
// assumes rms samples arrive with a one-cycle valid strobe
`timescale 1ns/10ps
`include "dsnrr_defs.vh"

module dsnrr_phase_mon (
  input wire clk_sys,
  input wire sys_rst,
  input wire [23:0] rmsHalf,
  input wire rmsValid,
  input wire [23:0] dipThr,
  input wire [23:0] swellThr,
  output reg [23:0] dipValue,
  output reg [23:0] swellValue,
  output reg inDip,
  output reg inSwell,
  output reg dipStart,
  output reg swellStart
);

  wire below;
  wire above;

  assign below = rmsHalf < dipThr;
  assign above = rmsHalf > swellThr;

  // ----------------------------------------------------------------------
  // judge and capture
  // ----------------------------------------------------------------------
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dipValue <= `DSNRR_RST_DIP_VAL;
      swellValue <= `DSNRR_RST_SWELL_VAL;
      inDip <= 1'b0;
      inSwell <= 1'b0;
      dipStart <= 1'b0;
      swellStart <= 1'b0;
    end else begin
      dipStart <= rmsValid & below & ~inDip;
      swellStart <= rmsValid & above & ~inSwell;
      if (rmsValid) begin
        inDip <= below;
        inSwell <= above;
        if (below) begin
          dipValue <= rmsHalf;
        end
        if (above) begin
          swellValue <= rmsHalf;
        end
      end
    end
  end

endmodule

// File: rtl/dsnrr_src_mux.v
// source selector for one datapath input, output registered
// assumes channel order current a-c, neutral, voltage a-c on the bus
`timescale 1ns/10ps
`include "dsnrr_defs.vh"

module dsnrr_src_mux (
  input wire clk_sys,
  input wire sys_rst,
  input wire [2:0] sourceSelect,
  input wire [167:0] adcChannels,
  input wire [23:0] nativeData,
  output reg [23:0] datapathIn
);

  reg [23:0] next_datapathIn;

  always @* begin
    next_datapathIn = nativeData;
    case (sourceSelect)
      `DSNRR_SRC_CUR_A: next_datapathIn = adcChannels[23:0];
      `DSNRR_SRC_CUR_B: next_datapathIn = adcChannels[47:24];
      `DSNRR_SRC_CUR_C: next_datapathIn = adcChannels[71:48];
      `DSNRR_SRC_CUR_N: next_datapathIn = adcChannels[95:72];
      `DSNRR_SRC_VOLT_A: next_datapathIn = adcChannels[119:96];
      `DSNRR_SRC_VOLT_B: next_datapathIn = adcChannels[143:120];
      `DSNRR_SRC_VOLT_C: next_datapathIn = adcChannels[167:144];
      default: next_datapathIn = nativeData;
    endcase
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      datapathIn <= 24'h000000;
    end else begin
      datapathIn <= next_datapathIn;
    end
  end

endmodule

// File: rtl/dsnrr_regs.v
// register slice: dip and swell thresholds and captures, no-load flags,
// voltage c source redirect, event pin and interrupt
// assumes an apb master on clk_sys and a datapath that strobes rms values
//
// The APB slave port was decided locally.
`timescale 1ns/10ps
`include "dsnrr_defs.vh"

module dsnrr_regs (
  input wire clk_sys,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [15:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire [71:0] rmsHalf,
  input wire [2:0] rmsValid,
  input wire [17:0] noLoadIn,
  input wire [167:0] adcChannels,
  output wire [23:0] vcDatapathIn,
  output reg eventPinN,
  output reg irq
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  reg [23:0] dipThreshold;
  reg [23:0] swellThreshold;
  reg [17:0] noLoadFlags;
  reg [2:0] voltageCSourceSelect;
  reg [5:0] eventEnable;
  reg [6:0] irqStatus;
  reg [6:0] irqMask;
  reg [6:0] readClearMask;
  reg [31:0] readWord;
  reg mapped;
  reg [6:0] next_irqStatus;
  wire [13:0] regIndex;
  wire setupPhase;
  wire accessDone;
  wire writeDone;
  wire readDone;
  wire [71:0] dipValues;
  wire [71:0] swellValues;
  wire [2:0] inDip;
  wire [2:0] inSwell;
  wire [2:0] dipStart;
  wire [2:0] swellStart;
  wire [6:0] irqSet;
  wire [5:0] eventActive;
  wire [31:0] dipThrWord;
  wire [31:0] swellThrWord;
  wire [31:0] redirectWord;
  wire [31:0] eventWord;
  wire [31:0] maskWord;
  wire [31:0] dipThrNew;
  wire [31:0] swellThrNew;
  wire [31:0] redirectNew;
  wire [31:0] eventNew;
  wire [31:0] maskNew;

  // ----------------------------------------------------------------------
  // byte-lane merge for writes
  // ----------------------------------------------------------------------
  function [31:0] mergeBytes;
    input [31:0] oldWord;
    input [31:0] newWord;
    input [3:0] strobe;
    integer lane;
    begin
      mergeBytes = oldWord;
      for (lane = 0; lane < 4; lane = lane + 1) begin
        if (strobe[lane]) begin
          mergeBytes[lane*8 +: 8] = newWord[lane*8 +: 8];
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  assign regIndex = paddr[15:2];
  assign setupPhase = psel & ~penable;
  assign accessDone = psel & penable;
  assign writeDone = accessDone & pwrite & mapped;
  assign readDone = accessDone & ~pwrite & mapped;
  assign pready = 1'b1;
  assign pslverr = accessDone & ~mapped;

  assign dipThrWord = {8'h00, dipThreshold};
  assign swellThrWord = {8'h00, swellThreshold};
  assign redirectWord = {11'h000, voltageCSourceSelect, 18'h00000};
  assign eventWord = {26'h0000000, eventEnable};
  assign maskWord = {25'h0000000, irqMask};

  // merged write words, cut to the field widths where stored
  assign dipThrNew = mergeBytes(dipThrWord, pwdata, pstrb);
  assign swellThrNew = mergeBytes(swellThrWord, pwdata, pstrb);
  assign redirectNew = mergeBytes(redirectWord, pwdata, pstrb);
  assign eventNew = mergeBytes(eventWord, pwdata, pstrb);
  assign maskNew = mergeBytes(maskWord, pwdata, pstrb);

  // ----------------------------------------------------------------------
  // per-phase monitors
  // ----------------------------------------------------------------------
  genvar ph;
  generate
    for (ph = 0; ph < 3; ph = ph + 1) begin : gPhase
      dsnrr_phase_mon uMon (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .rmsHalf(rmsHalf[ph*24 +: 24]),
        .rmsValid(rmsValid[ph]),
        .dipThr(dipThreshold),
        .swellThr(swellThreshold),
        .dipValue(dipValues[ph*24 +: 24]),
        .swellValue(swellValues[ph*24 +: 24]),
        .inDip(inDip[ph]),
        .inSwell(inSwell[ph]),
        .dipStart(dipStart[ph]),
        .swellStart(swellStart[ph])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // voltage c source redirect
  // ----------------------------------------------------------------------
  dsnrr_src_mux uVcMux (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .sourceSelect(voltageCSourceSelect),
    .adcChannels(adcChannels),
    .nativeData(adcChannels[167:144]),
    .datapathIn(vcDatapathIn)
  );

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  always @* begin
    readWord = 32'h00000000;
    mapped = 1'b1;
    case (regIndex)
      `DSNRR_IDX_DIP_THR: readWord = dipThrWord;
      `DSNRR_IDX_DIP_A: readWord = {8'h00, dipValues[23:0]};
      `DSNRR_IDX_DIP_B: readWord = {8'h00, dipValues[47:24]};
      `DSNRR_IDX_DIP_C: readWord = {8'h00, dipValues[71:48]};
      `DSNRR_IDX_SWELL_THR: readWord = swellThrWord;
      `DSNRR_IDX_SWELL_A: readWord = {8'h00, swellValues[23:0]};
      `DSNRR_IDX_SWELL_B: readWord = {8'h00, swellValues[47:24]};
      `DSNRR_IDX_SWELL_C: readWord = {8'h00, swellValues[71:48]};
      `DSNRR_IDX_NOLOAD: readWord = {14'h0000, noLoadFlags};
      `DSNRR_IDX_REDIRECT: readWord = redirectWord;
      `DSNRR_IDX_EVT_EN: readWord = eventWord;
      `DSNRR_IDX_IRQ_STAT: readWord = {25'h0000000, irqStatus};
      `DSNRR_IDX_IRQ_MASK: readWord = maskWord;
      default: begin
        readWord = 32'h00000000;
        mapped = 1'b0;
      end
    endcase
  end

  // read data is caught in the setup cycle and held through the access
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
      readClearMask <= 7'h00;
    end else if (setupPhase & ~pwrite) begin
      prdata <= readWord;
      if (regIndex == `DSNRR_IDX_IRQ_STAT) begin
        readClearMask <= irqStatus;
      end else begin
        readClearMask <= 7'h00;
      end
    end
  end

  // ----------------------------------------------------------------------
  // thresholds
  // ----------------------------------------------------------------------
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dipThreshold <= `DSNRR_RST_DIP_THR;
      swellThreshold <= `DSNRR_RST_SWELL_THR;
    end else if (writeDone) begin
      if (regIndex == `DSNRR_IDX_DIP_THR) begin
        dipThreshold <= dipThrNew[23:0];
      end
      if (regIndex == `DSNRR_IDX_SWELL_THR) begin
        swellThreshold <= swellThrNew[23:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // redirect, event enables and interrupt mask
  // ----------------------------------------------------------------------
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      voltageCSourceSelect <= `DSNRR_RST_SRC;
      eventEnable <= `DSNRR_RST_EVT;
      irqMask <= `DSNRR_RST_IRQ;
    end else if (writeDone) begin
      if (regIndex == `DSNRR_IDX_REDIRECT) begin
        voltageCSourceSelect <=
          redirectNew[`DSNRR_SRC_MSB:`DSNRR_SRC_LSB];
      end
      if (regIndex == `DSNRR_IDX_EVT_EN) begin
        eventEnable <= eventNew[5:0];
      end
      if (regIndex == `DSNRR_IDX_IRQ_MASK) begin
        irqMask <= maskNew[6:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // no-load flags, sampled from the datapath, writes ignored
  // ----------------------------------------------------------------------
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      noLoadFlags <= `DSNRR_RST_NOLOAD;
    end else begin
      noLoadFlags[5:0] <= noLoadIn[5:0];
      noLoadFlags[11:6] <= noLoadIn[11:6];
      noLoadFlags[17:12] <= noLoadIn[17:12];
    end
  end

  // ----------------------------------------------------------------------
  // event pin
  // ----------------------------------------------------------------------
  assign eventActive = {inSwell, inDip} & eventEnable;

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      eventPinN <= 1'b1;
    end else begin
      eventPinN <= ~|eventActive;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt status, cleared by read, set wins
  // ----------------------------------------------------------------------
  assign irqSet = {|(noLoadIn & ~noLoadFlags), swellStart, dipStart};

  always @* begin
    next_irqStatus = irqStatus;
    if (readDone && regIndex == `DSNRR_IDX_IRQ_STAT) begin
      next_irqStatus = irqStatus & ~readClearMask;
    end
    next_irqStatus = next_irqStatus | irqSet;
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irqStatus <= `DSNRR_RST_IRQ;
      irq <= 1'b0;
    end else begin
      irqStatus <= next_irqStatus;
      irq <= |(next_irqStatus & irqMask);
    end
  end

endmodule

// File: testbench/dsnrr_regs_monitor.sv
// checker on the ports of the register slice
// assumes binding onto dsnrr_regs with apb on clk_sys
`timescale 1ns/10ps
`include "dsnrr_defs.vh"
module dsnrr_regs_monitor (
  input wire clk_sys,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [15:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire [71:0] rmsHalf,
  input wire [2:0] rmsValid,
  input wire [17:0] noLoadIn,
  input wire [167:0] adcChannels,
  input wire [23:0] vcDatapathIn,
  input wire eventPinN,
  input wire irq
);
  // ----
  // shadow of written fields
  // ----
  wire [13:0] idx = paddr[15:2];
  wire rdSet = psel && !penable && !pwrite;
  wire wrAcc = psel && penable && pwrite;
  wire mapped = (idx >= `DSNRR_IDX_DIP_THR && idx <= `DSNRR_IDX_SWELL_C) ||
    idx == `DSNRR_IDX_NOLOAD || idx == `DSNRR_IDX_REDIRECT ||
    (idx >= `DSNRR_IDX_EVT_EN && idx <= `DSNRR_IDX_IRQ_MASK);
  reg [2:0] selT;
  reg [5:0] evtT;
  reg [6:0] maskT;
  reg [23:0] dipT;
  wire [23:0] expVc = (selT == 3'h7) ? adcChannels[167:144] :
    adcChannels[selT*24 +: 24];
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      selT <= `DSNRR_RST_SRC;
      evtT <= 6'h00;
      maskT <= 7'h00;
      dipT <= 24'h000000;
    end else if (wrAcc) begin
      if (idx == `DSNRR_IDX_REDIRECT && pstrb[2])
        selT <= pwdata[20:18];
      if (idx == `DSNRR_IDX_EVT_EN && pstrb[0])
        evtT <= pwdata[5:0];
      if (idx == `DSNRR_IDX_IRQ_MASK && pstrb[0])
        maskT <= pwdata[6:0];
      if (idx == `DSNRR_IDX_DIP_THR && pstrb[2:0] == 3'h7)
        dipT <= pwdata[23:0];
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_ready_always:
    assert property (pready) else $error("pready low");
  a_err_access:
    assert property (pslverr |-> psel && penable) else $error("stray error");
  a_err_unmapped:
    assert property (psel && penable |-> pslverr == !mapped)
    else $error("error flag wrong");
  a_rd_unmapped:
    assert property (rdSet && !mapped |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_rd_hold:
    assert property (!rdSet |=> $stable(prdata)) else $error("prdata moved");
  a_noload_read:
    assert property (rdSet && idx == `DSNRR_IDX_NOLOAD && $stable(noLoadIn)
      |=> prdata == {14'h0000, $past(noLoadIn)}) else $error("no-load read");
  a_vc_route:
    assert property (!$past(sys_rst) |-> vcDatapathIn == $past(expVc))
    else $error("vc input wrong");
  a_irq_masked:
    assert property (maskT == 7'h00 |=> !irq) else $error("masked irq");
  a_evt_idle:
    assert property (evtT == 6'h00 [*2] |=> eventPinN)
    else $error("event without enable");
  a_dip_event:
    assert property (rmsValid[0] && rmsHalf[23:0] < dipT && evtT[0]
      |-> ##2 !eventPinN) else $error("dip event missing");
  c_redirect: cover property (wrAcc && idx == `DSNRR_IDX_REDIRECT);
  c_event: cover property ($fell(eventPinN));
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
endmodule
bind dsnrr_regs dsnrr_regs_monitor u_mon (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .rmsHalf(rmsHalf),
  .rmsValid(rmsValid), .noLoadIn(noLoadIn), .adcChannels(adcChannels),
  .vcDatapathIn(vcDatapathIn), .eventPinN(eventPinN), .irq(irq));

// File: testbench/dsnrr_regs_tb_top.sv
// self-checking bench of the register slice
// assumes dsnrr_regs and its checker compiled before
`timescale 1ns/10ps
`include "dsnrr_defs.vh"
module dsnrr_regs_tb_top;
  reg clk_sys, sys_rst, psel, penable, pwrite, errSeen;
  reg [15:0] paddr;
  reg [31:0] pwdata, rd;
  reg [3:0] pstrb;
  reg [71:0] rmsHalf;
  reg [2:0] rmsValid;
  reg [17:0] noLoadIn;
  reg [167:0] adcChannels;
  wire pready, pslverr, eventPinN, irq;
  wire [31:0] prdata;
  wire [23:0] vcDatapathIn;
  integer n_fail, num_checks, i;
  dsnrr_regs u_dsnrr_regs (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .rmsHalf(rmsHalf), .rmsValid(rmsValid),
    .noLoadIn(noLoadIn), .adcChannels(adcChannels),
    .vcDatapathIn(vcDatapathIn), .eventPinN(eventPinN), .irq(irq));
  // ----
  // shared tasks
  // ----
  task complete_run;
    begin
      $display("checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
    end
  endtask
  task apb(input wr, input [13:0] ix, input [31:0] wd);
    integer k;
    begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {ix, 2'b00};
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      k = 0;
      do begin
        @(posedge clk_sys);
        k = k + 1;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
        n_fail = n_fail + 1;
        complete_run;
      end
      rd = prdata;
      errSeen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task rdChk(input [13:0] ix, input [31:0] exp, input string nm);
    begin
      apb(1'b0, ix, 32'h0);
      chk(nm, rd, exp);
    end
  endtask
  task pulse(input [71:0] v);
    begin
      rmsHalf <= v;
      rmsValid <= 3'h7;
      @(posedge clk_sys);
      rmsValid <= 3'h0;
      repeat (3) @(posedge clk_sys);
    end
  endtask
  // ----
  // scenarios
  // ----
  task tResets;
    begin
      rdChk(`DSNRR_IDX_DIP_THR, 32'h0, "dip thr");
      rdChk(`DSNRR_IDX_SWELL_THR, 32'h00ffffff, "swell thr");
      for (i = 0; i < 3; i = i + 1) begin
        rdChk(`DSNRR_IDX_DIP_A + i, 32'h007fffff, "dip val");
        rdChk(`DSNRR_IDX_SWELL_A + i, 32'h0, "swell val");
        rdChk(`DSNRR_IDX_EVT_EN + i, 32'h0, "own reg");
      end
      rdChk(`DSNRR_IDX_NOLOAD, 32'h0, "no-load");
      rdChk(`DSNRR_IDX_REDIRECT, 32'h001c0000, "redirect");
      chk("vc input", vcDatapathIn, adcChannels[167:144]);
    end
  endtask
  task tRoWrite;
    begin
      apb(1'b1, `DSNRR_IDX_DIP_THR, 32'hffffffff);
      rdChk(`DSNRR_IDX_DIP_THR, 32'h00ffffff, "dip thr");
      apb(1'b1, `DSNRR_IDX_SWELL_THR, 32'h12abcdef);
      rdChk(`DSNRR_IDX_SWELL_THR, 32'h00abcdef, "swell thr");
      apb(1'b1, `DSNRR_IDX_DIP_B, 32'h0);
      rdChk(`DSNRR_IDX_DIP_B, 32'h007fffff, "ro dip");
      apb(1'b1, `DSNRR_IDX_NOLOAD, 32'hffffffff);
      rdChk(`DSNRR_IDX_NOLOAD, 32'h0, "ro no-load");
    end
  endtask
  task tNoLoad;
    begin
      for (i = 0; i < 18; i = i + 1) begin
        noLoadIn <= 18'h1 << i;
        @(posedge clk_sys);
        rdChk(`DSNRR_IDX_NOLOAD, 32'h1 << i, "flag");
      end
      noLoadIn <= 18'h0;
      @(posedge clk_sys);
    end
  endtask
  task tRedirect;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        apb(1'b1, `DSNRR_IDX_REDIRECT, 32'hffe3ffff | (i << 18));
        rdChk(`DSNRR_IDX_REDIRECT, i << 18, "redirect");
        chk("vc input", vcDatapathIn,
          adcChannels[(i == 7 ? 6 : i)*24 +: 24]);
      end
    end
  endtask
  task tCapture;
    begin
      apb(1'b1, `DSNRR_IDX_DIP_THR, 32'h100000);
      apb(1'b1, `DSNRR_IDX_SWELL_THR, 32'h600000);
      pulse({24'h300000, 24'h700000, 24'h080000});
      rdChk(`DSNRR_IDX_DIP_A, 32'h080000, "dip a");
      rdChk(`DSNRR_IDX_SWELL_B, 32'h700000, "swell b");
      rdChk(`DSNRR_IDX_DIP_B, 32'h7fffff, "dip b");
      rdChk(`DSNRR_IDX_SWELL_A, 32'h0, "swell a");
      pulse({24'h100000, 24'h600000, 24'h300000});
      rdChk(`DSNRR_IDX_DIP_C, 32'h7fffff, "dip c");
      rdChk(`DSNRR_IDX_SWELL_B, 32'h700000, "swell b");
      rdChk(`DSNRR_IDX_DIP_A, 32'h080000, "dip a");
    end
  endtask
  task tEvent;
    begin
      apb(1'b0, `DSNRR_IDX_IRQ_STAT, 32'h0);
      apb(1'b1, `DSNRR_IDX_EVT_EN, 32'h1);
      apb(1'b1, `DSNRR_IDX_IRQ_MASK, 32'h1);
      chk("event", eventPinN, 1);
      pulse({24'h300000, 24'h300000, 24'h050000});
      chk("event", eventPinN, 0);
      chk("irq", irq, 1);
      rdChk(`DSNRR_IDX_IRQ_STAT, 32'h1, "irq status");
      @(posedge clk_sys);
      chk("irq", irq, 0);
      rdChk(`DSNRR_IDX_IRQ_STAT, 32'h0, "irq status");
      apb(1'b1, `DSNRR_IDX_EVT_EN, 32'h8);
      @(posedge clk_sys);
      chk("event", eventPinN, 1);
      apb(1'b1, `DSNRR_IDX_IRQ_MASK, 32'h0);
      apb(1'b1, `DSNRR_IDX_EVT_EN, 32'h1);
      pulse({24'h300000, 24'h300000, 24'h300000});
      chk("event", eventPinN, 1);
      pulse({24'h300000, 24'h300000, 24'h050000});
      chk("event", eventPinN, 0);
      chk("irq", irq, 0);
    end
  endtask
  task tUnmapped;
    begin
      rdChk(14'h0400, 32'h0, "unmapped");
      chk("slave error", errSeen, 1);
      apb(1'b1, 14'h0418, 32'hffffffff);
      chk("slave error", errSeen, 1);
    end
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    n_fail = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = 0;
    pstrb = 4'hf;
    rmsHalf = 72'h0;
    rmsValid = 3'h0;
    noLoadIn = 18'h0;
    for (i = 0; i < 7; i = i + 1)
      adcChannels[i*24 +: 24] = 24'h111111 * (i + 1);
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    tResets;
    tRoWrite;
    tNoLoad;
    tRedirect;
    tCapture;
    tEvent;
    tUnmapped;
    complete_run;
  end
endmodule
